// ---- verilog/cbh_exec.sv ----
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module cbh_exec (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_hw0_i,
	input wire logic [15:0] instr_hw1_i,
	input wire logic instr_wide_i,
	input wire logic in_cond_block_i,
	input wire logic cond_pass_i,
	input wire logic [cbh_pkg::XLEN-1:0] first_operand_i,
	input wire logic [cbh_pkg::XLEN-1:0] second_operand_i,
	input wire logic mem_drained_i,
	input wire logic ctrl_visible_i,
	input wire logic [cbh_pkg::AW-1:0] reg_addr_i,
	input wire logic [cbh_pkg::XLEN-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [cbh_pkg::XLEN-1:0] reg_rdata_o,
	output logic [3:0] flags_o,
	output logic prio_mask_o,
	output logic fault_mask_o,
	output logic stall_o,
	output logic mem_hold_o,
	output logic barrier_full_o,
	output logic debug_hint_o,
	output logic [3:0] debug_option_o,
	output logic not_permitted_o
);
	import cbh_pkg::*;

	logic taken;
	logic is_narrow_lo;
	logic is_narrow_hi;
	logic is_wide;
	logic is_compare;
	logic is_psc;
	logic is_debug;
	logic is_order;
	logic is_complete;
	logic [3:0] option;
	cbh_shift_t shift_type;
	logic [4:0] shift_amount;
	logic [XLEN-1:0] shifted;
	logic [XLEN:0] sum;
	logic [3:0] compare_flags;

	logic [3:0] flags_reg;
	logic [3:0] flags_next;
	logic [1:0] masks_reg;
	logic [1:0] masks_next;
	logic hint_reg;
	logic hint_next;
	logic [3:0] hint_opt_reg;
	logic [3:0] hint_opt_next;
	logic notperm_reg;
	logic notperm_next;

	cbh_bar_t bar_reg;
	cbh_bar_t bar_next;
	logic stall_reg;
	logic stall_next;
	logic hold_reg;
	logic hold_next;
	logic full_reg;
	logic full_next;

	logic sticky_reg;
	logic sticky_next;
	logic [XLEN-1:0] rdata_reg;
	logic [XLEN-1:0] rdata_next;

	// Decode; a stalled pipeline offers nothing new
	always_comb
	begin
		taken = ce_i && instr_valid_i && !stall_reg;
		is_narrow_lo = !instr_wide_i && instr_hw0_i[15:6] == COMPARE_NARROW_LO;
		is_narrow_hi = !instr_wide_i && instr_hw0_i[15:8] == COMPARE_NARROW_HI;
		is_wide = instr_wide_i && instr_hw0_i[15:4] == COMPARE_WIDE_HW0
			&& instr_hw1_i[11:8] == COMPARE_WIDE_HW1;
		is_compare = is_narrow_lo || is_narrow_hi || is_wide;
		is_psc = !instr_wide_i && instr_hw0_i[15:5] == PSC_HW0;
		is_debug = instr_wide_i && instr_hw0_i[15:4] == HINT_HW0
			&& (instr_hw1_i & HINT_HW1_MASK) == DEBUG_HW1;
		is_order = instr_wide_i && instr_hw0_i[15:4] == BAR_HW0
			&& (instr_hw1_i & BAR_HW1_MASK) == ORDER_HW1;
		is_complete = instr_wide_i && instr_hw0_i[15:4] == BAR_HW0
			&& (instr_hw1_i & BAR_HW1_MASK) == COMPLETE_HW1;
		option = instr_hw1_i[3:0];
		// Narrow forms carry no shift field
		shift_type = is_wide ? cbh_shift_t'(instr_hw1_i[5:4]) : CBH_LSL;
		shift_amount = is_wide ? {instr_hw1_i[14:12], instr_hw1_i[7:6]} : 5'h0;
	end

	cbh_shift u_shift (
		.value_i(second_operand_i),
		.type_i(shift_type),
		.amount_i(shift_amount),
		.carry_i(flags_reg[FLAG_C]),
		.result_o(shifted)
	);

	always_comb
	begin
		sum = {1'b0, first_operand_i} + {1'b0, ~shifted} + {{XLEN{1'b0}}, 1'b1};
		compare_flags[FLAG_N] = sum[XLEN-1];
		compare_flags[FLAG_Z] = sum[XLEN-1:0] == '0;
		compare_flags[FLAG_C] = sum[XLEN];
		compare_flags[FLAG_V] = (first_operand_i[XLEN-1] != shifted[XLEN-1])
			&& (sum[XLEN-1] != first_operand_i[XLEN-1]);
	end

	// Architectural state: flags, masks, debug hint; execution beats a software write
	always_comb
	begin
		flags_next = flags_reg;
		masks_next = masks_reg;
		hint_next = 1'b0;
		hint_opt_next = hint_opt_reg;
		notperm_next = 1'b0;
		if (reg_wr_i && reg_addr_i == ADDR_FLAGS)
			flags_next = reg_wdata_i[3:0];
		if (reg_wr_i && reg_addr_i == ADDR_MASKS)
			masks_next = reg_wdata_i[1:0];
		if (taken && is_psc && in_cond_block_i)
			notperm_next = 1'b1;
		else if (taken && cond_pass_i)
		begin
			// Result is discarded, only NZCV are written
			if (is_compare)
				flags_next = compare_flags;
			if (is_psc)
			begin
				if (instr_hw0_i[1])
					masks_next[MASK_PRI] = instr_hw0_i[4];
				if (instr_hw0_i[0])
					masks_next[MASK_FLT] = instr_hw0_i[4];
			end
			// Hint touches no flag or mask, only the debug port
			if (is_debug)
			begin
				hint_next = 1'b1;
				hint_opt_next = option;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			flags_reg <= FLAGS_RESET;
			masks_reg <= MASKS_RESET;
			hint_reg <= 1'b0;
			hint_opt_reg <= 4'h0;
			notperm_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			flags_reg <= flags_next;
			masks_reg <= masks_next;
			hint_reg <= hint_next;
			hint_opt_reg <= hint_opt_next;
			notperm_reg <= notperm_next;
		end
	end

	// Barrier sequencing; every option is treated as full system, reserved ones too
	always_comb
	begin
		bar_next = bar_reg;
		stall_next = stall_reg;
		hold_next = hold_reg;
		full_next = full_reg;
		case (bar_reg)
			CBH_IDLE:
			begin
				stall_next = 1'b0;
				hold_next = 1'b0;
			end
			CBH_ORDER:
				if (mem_drained_i)
				begin
					bar_next = CBH_IDLE;
					hold_next = 1'b0;
				end
			CBH_COMPLETE:
				if (mem_drained_i && ctrl_visible_i)
				begin
					bar_next = CBH_IDLE;
					stall_next = 1'b0;
					hold_next = 1'b0;
				end
			default:
			begin
				bar_next = CBH_IDLE;
				stall_next = 1'b0;
				hold_next = 1'b0;
			end
		endcase
		// Completion during an ordering wait simply upgrades the wait
		if (taken && cond_pass_i && is_complete)
		begin
			bar_next = CBH_COMPLETE;
			stall_next = 1'b1;
			hold_next = 1'b1;
			full_next = 1'b1;
		end
		else if (taken && cond_pass_i && is_order && bar_reg != CBH_COMPLETE)
		begin
			// Only memory traffic is held, so no stall here
			bar_next = CBH_ORDER;
			hold_next = 1'b1;
			full_next = 1'b1;
		end
		else if (bar_next == CBH_IDLE)
			full_next = 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bar_reg <= CBH_IDLE;
			stall_reg <= 1'b0;
			hold_reg <= 1'b0;
			full_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			bar_reg <= bar_next;
			stall_reg <= stall_next;
			hold_reg <= hold_next;
			full_reg <= full_next;
		end
	end

	// Register port; sticky bit is write-one-to-clear, a new event wins
	always_comb
	begin
		sticky_next = sticky_reg;
		if (reg_wr_i && reg_addr_i == ADDR_STATUS && reg_wdata_i[ST_NOTPERM])
			sticky_next = 1'b0;
		if (notperm_next)
			sticky_next = 1'b1;
		rdata_next = '0;
		if (reg_rd_i)
			case (reg_addr_i)
				ADDR_FLAGS: rdata_next[3:0] = flags_reg;
				ADDR_MASKS: rdata_next[1:0] = masks_reg;
				ADDR_STATUS:
				begin
					rdata_next[ST_STALL] = stall_reg;
					rdata_next[ST_HOLD] = hold_reg;
					rdata_next[ST_NOTPERM] = sticky_reg;
				end
				ADDR_DEBUG: rdata_next[3:0] = hint_opt_reg;
				default: rdata_next = '0;
			endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sticky_reg <= 1'b0;
			rdata_reg <= '0;
		end
		else if (ce_i)
		begin
			sticky_reg <= sticky_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign flags_o = flags_reg;
	assign prio_mask_o = masks_reg[MASK_PRI];
	assign fault_mask_o = masks_reg[MASK_FLT];
	assign stall_o = stall_reg;
	assign mem_hold_o = hold_reg;
	assign barrier_full_o = full_reg;
	assign debug_hint_o = hint_reg;
	assign debug_option_o = hint_opt_reg;
	assign not_permitted_o = notperm_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);

	eq_flags_a: assert property (taken && cond_pass_i && (is_narrow_lo || is_narrow_hi)
		&& first_operand_i == second_operand_i |=> flags_o[FLAG_Z] && flags_o[FLAG_C]
		&& !flags_o[FLAG_N] && !flags_o[FLAG_V])
		else $error("equal compare gave wrong flags");
	shift_flags_a: assert property (taken && cond_pass_i && is_wide && !reg_wr_i
		&& instr_hw1_i[5:4] == 2'b00 && {instr_hw1_i[14:12], instr_hw1_i[7:6]} == 5'h4
		&& first_operand_i == {second_operand_i[XLEN-5:0], 4'h0} |=> flags_o[FLAG_Z])
		else $error("wide compare ignored its shift");
	psc_set_a: assert property (taken && cond_pass_i && is_psc && !in_cond_block_i
		&& instr_hw0_i[4] && instr_hw0_i[1] |=> prio_mask_o ##1 1'b1)
		else $error("state change failed to set priority mask");
	psc_block_a: assert property (taken && is_psc && in_cond_block_i && !reg_wr_i
		|=> not_permitted_o && masks_reg == $past(masks_reg))
		else $error("state change inside block not refused");
	hint_pass_a: assert property (taken && cond_pass_i && is_debug && !reg_wr_i
		|=> debug_hint_o && debug_option_o == $past(instr_hw1_i[3:0])
		&& flags_o == $past(flags_o))
		else $error("debug hint option lost or state changed");
	order_flow_a: assert property (taken && cond_pass_i && is_order && !stall_o
		|=> mem_hold_o && !stall_o && barrier_full_o)
		else $error("ordering barrier stalled or did not hold memory");
	complete_stall_a: assert property (taken && cond_pass_i && is_complete
		|=> stall_o && mem_hold_o && barrier_full_o)
		else $error("completion barrier did not stall");
	complete_wait_a: assert property (stall_o && !(mem_drained_i && ctrl_visible_i)
		|=> stall_o)
		else $error("completion barrier ended too early");
	complete_end_a: assert property (ce_i && stall_o && mem_drained_i && ctrl_visible_i
		&& !(instr_valid_i && is_complete) |=> !stall_o && !mem_hold_o)
		else $error("completion barrier did not release");
	cond_fail_a: assert property (taken && !cond_pass_i && !reg_wr_i && !is_psc
		|=> flags_o == $past(flags_o) && masks_reg == $past(masks_reg) && !debug_hint_o)
		else $error("failed condition changed state");
endmodule : cbh_exec

// ---- verilog/cbh_pkg.sv ----
package cbh_pkg;
	localparam int XLEN = 32;
	localparam int AW = 4;
	localparam logic [AW-1:0] ADDR_FLAGS = 4'h0;
	localparam logic [AW-1:0] ADDR_MASKS = 4'h4;
	localparam logic [AW-1:0] ADDR_STATUS = 4'h8;
	localparam logic [AW-1:0] ADDR_DEBUG = 4'hC;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 0;
	localparam int MASK_PRI = 0;
	localparam int MASK_FLT = 1;
	localparam int ST_STALL = 0;
	localparam int ST_HOLD = 1;
	localparam int ST_NOTPERM = 2;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [1:0] MASKS_RESET = 2'h0;
	localparam logic [3:0] FULL_SYSTEM_OPTION = 4'hF;
	// First halfword patterns, plus the wide compare's second halfword field
	localparam logic [9:0] COMPARE_NARROW_LO = 10'h10A;
	localparam logic [7:0] COMPARE_NARROW_HI = 8'h45;
	localparam logic [11:0] COMPARE_WIDE_HW0 = 12'hEBB;
	localparam logic [3:0] COMPARE_WIDE_HW1 = 4'hF;
	localparam logic [10:0] PSC_HW0 = 11'h5B3;
	localparam logic [11:0] HINT_HW0 = 12'hF3A;
	localparam logic [11:0] BAR_HW0 = 12'hF3B;
	// Second halfword masks and patterns
	localparam logic [15:0] HINT_HW1_MASK = 16'hD7F0;
	localparam logic [15:0] DEBUG_HW1 = 16'h80F0;
	localparam logic [15:0] BAR_HW1_MASK = 16'hD0F0;
	localparam logic [15:0] ORDER_HW1 = 16'h8050;
	localparam logic [15:0] COMPLETE_HW1 = 16'h8040;
	typedef enum logic [1:0] {
		CBH_LSL = 2'b00,
		CBH_LSR = 2'b01,
		CBH_ASR = 2'b10,
		CBH_ROR = 2'b11
	} cbh_shift_t;
	typedef enum logic [1:0] {
		CBH_IDLE = 2'b00,
		CBH_ORDER = 2'b01,
		CBH_COMPLETE = 2'b10
	} cbh_bar_t;
endpackage : cbh_pkg

// ---- verilog/cbh_shift.sv ----
`timescale 1ns/1ps
module cbh_shift (
	input wire logic [cbh_pkg::XLEN-1:0] value_i,
	input wire cbh_pkg::cbh_shift_t type_i,
	input wire logic [4:0] amount_i,
	input wire logic carry_i,
	output logic [cbh_pkg::XLEN-1:0] result_o
);
	import cbh_pkg::*;
	logic [2*XLEN-1:0] doubled;
	always_comb
	begin
		doubled = {value_i, value_i} >> amount_i;
		// Zero amount means a 32-place shift for LSR/ASR and RRX for ROR
		case (type_i)
			CBH_LSL: result_o = value_i << amount_i;
			CBH_LSR: result_o = (amount_i == 5'h0) ? '0 : value_i >> amount_i;
			CBH_ASR: result_o = (amount_i == 5'h0) ? {XLEN{value_i[XLEN-1]}}
				: XLEN'($signed(value_i) >>> amount_i);
			CBH_ROR: result_o = (amount_i == 5'h0) ? {carry_i, value_i[XLEN-1:1]}
				: doubled[XLEN-1:0];
			default: result_o = value_i;
		endcase
	end
endmodule : cbh_shift

// ---- test/cbh_mem_model.sv ----
`timescale 1ns/1ps
module cbh_mem_model (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic hold_i,
	input wire logic [3:0] lat_i,
	output logic drained_o,
	output logic ctrl_vis_o
);
	logic [3:0] cnt_reg;
	// Older accesses stay in flight lat_i cycles once held
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cnt_reg <= 4'h0;
		else if (!hold_i)
			cnt_reg <= 4'h0;
		else if (cnt_reg != 4'hF)
			cnt_reg <= cnt_reg + 4'h1;
	end
	assign drained_o = hold_i && (cnt_reg >= lat_i);
	// Control space effects land a cycle after the drain, never earlier; with lat_i at 15 they never land
	assign ctrl_vis_o = hold_i && (cnt_reg > lat_i);
endmodule : cbh_mem_model

// ---- test/compare_barrier_hint_exec_tb.sv ----
`timescale 1ns/1ps
module compare_barrier_hint_exec_tb;
	import cbh_pkg::*;
	typedef struct {
		logic [15:0] hw0;
		logic [15:0] hw1;
		logic wide;
		logic cond;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] sb;
	} cbh_row_t;
	logic clk_i = 1'h0;
	logic arst_n_i = 1'h0;
	logic ce_i = 1'h1;
	logic instr_valid_i = 1'h0;
	logic [15:0] instr_hw0_i = 16'h0000;
	logic [15:0] instr_hw1_i = 16'h0000;
	logic instr_wide_i = 1'h0;
	logic in_cond_block_i = 1'h0;
	logic cond_pass_i = 1'h0;
	logic [XLEN-1:0] first_operand_i = '0;
	logic [XLEN-1:0] second_operand_i = '0;
	logic [AW-1:0] reg_addr_i = 4'h0;
	logic [XLEN-1:0] reg_wdata_i = '0;
	logic reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0;
	logic [3:0] lat = 4'h0;
	logic last_dr = 1'h0;
	logic last_sc = 1'h0;
	logic mem_drained_i, ctrl_visible_i, prio_mask_o, fault_mask_o, stall_o, mem_hold_o;
	logic barrier_full_o, debug_hint_o, not_permitted_o;
	logic [XLEN-1:0] reg_rdata_o;
	logic [3:0] flags_o, debug_option_o;
	logic [3:0] expf = 4'h0;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	// Seventh column is the second operand after the shift
	cbh_row_t rows [9] = '{
		'{16'h4288, 16'h1F01, 1'h0, 1'h1, 32'h5, 32'h5, 32'h5},
		'{16'h4508, 16'h0000, 1'h0, 1'h1, 32'h3, 32'h5, 32'h5},
		'{16'h4288, 16'h0000, 1'h0, 1'h1, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF},
		'{16'hEBB0, 16'h1F01, 1'h1, 1'h1, 32'h10, 32'h1, 32'h10},
		'{16'hEBB0, 16'h0F31, 1'h1, 1'h1, 32'h0, 32'h2, 32'h80000001},
		'{16'hEBB0, 16'h0F61, 1'h1, 1'h1, 32'h40000000, 32'h80000000, 32'hC0000000},
		'{16'hEBB0, 16'h2F11, 1'h1, 1'h1, 32'h00123457, 32'h12345678, 32'h00123456},
		'{16'hEBB0, 16'h1F31, 1'h1, 1'h1, 32'hF0000000, 32'hF, 32'hF0000000},
		'{16'h4288, 16'h0000, 1'h0, 1'h0, 32'h1, 32'h2, 32'h2}
	};
	// State change: condition, in block, fault mask, priority mask
	logic [15:0] psc_hw [5] = '{16'hB673, 16'hB662, 16'hB661, 16'hB673, 16'hB673};
	logic [3:0] psc_x [5] = '{4'hB, 4'hA, 4'h8, 4'hC, 4'h0};

	cbh_exec i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
		.instr_valid_i(instr_valid_i), .instr_hw0_i(instr_hw0_i), .instr_hw1_i(instr_hw1_i),
		.instr_wide_i(instr_wide_i), .in_cond_block_i(in_cond_block_i),
		.cond_pass_i(cond_pass_i), .first_operand_i(first_operand_i),
		.second_operand_i(second_operand_i), .mem_drained_i(mem_drained_i),
		.ctrl_visible_i(ctrl_visible_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.flags_o(flags_o), .prio_mask_o(prio_mask_o), .fault_mask_o(fault_mask_o),
		.stall_o(stall_o), .mem_hold_o(mem_hold_o), .barrier_full_o(barrier_full_o),
		.debug_hint_o(debug_hint_o), .debug_option_o(debug_option_o),
		.not_permitted_o(not_permitted_o));
	cbh_mem_model i_mem (.clk_i(clk_i), .arst_n_i(arst_n_i), .hold_i(mem_hold_o),
		.lat_i(lat), .drained_o(mem_drained_i), .ctrl_vis_o(ctrl_visible_i));

	always #5 clk_i = ~clk_i;

	function automatic logic [3:0] nzcv(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] s;
		s = {1'h0, a} + {1'h0, ~b} + 33'h1;
		return {s[31], s[31:0] == 32'h0, s[32], (a[31] != b[31]) && (s[31] != a[31])};
	endfunction : nzcv

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic issue(input logic [15:0] h0, input logic [15:0] h1, input logic w,
		input logic c, input logic blk, input logic [31:0] a, input logic [31:0] b);
		@(posedge clk_i);
		instr_valid_i <= 1'h1;
		instr_hw0_i <= h0;
		instr_hw1_i <= h1;
		instr_wide_i <= w;
		cond_pass_i <= c;
		in_cond_block_i <= blk;
		first_operand_i <= a;
		second_operand_i <= b;
		@(posedge clk_i);
		instr_valid_i <= 1'h0;
		@(negedge clk_i);
	endtask : issue

	task automatic reg_access(input logic wr, input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= wr;
		reg_rd_i <= !wr;
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'h0;
		reg_rd_i <= 1'h0;
		@(negedge clk_i);
		if (!wr)
			chk(reg_rdata_o, d, "read");
	endtask : reg_access

	// Bounded wait; the release must follow an edge that saw the drain
	task automatic wait_free(input logic need_ctrl);
		for (int i = 0; i < 40 && mem_hold_o !== 1'h0; i++)
			@(negedge clk_i);
		chk({stall_o, barrier_full_o, last_dr, last_sc | !need_ctrl}, 32'h3, "release");
	endtask : wait_free

	// Only edges with the hold up count, so a fast release is judged by its own edge
	always @(posedge clk_i)
	begin
		if (mem_hold_o)
		begin
			last_dr <= mem_drained_i;
			last_sc <= ctrl_visible_i;
		end
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'h1;
		@(negedge clk_i);
		chk({flags_o, prio_mask_o, fault_mask_o, stall_o, mem_hold_o}, '0, "reset");
		for (int i = 0; i < 9; i++)
		begin
			issue(rows[i].hw0, rows[i].hw1, rows[i].wide, rows[i].cond, 1'h0, rows[i].a, rows[i].b);
			expf = rows[i].cond ? nzcv(rows[i].a, rows[i].sb) : expf;
			chk(flags_o, expf, "compare");
		end
		$display("compare test done");
		for (int i = 0; i < 5; i++)
		begin
			issue(psc_hw[i], 16'h0000, 1'h0, psc_x[i][3], psc_x[i][2], '0, '0);
			chk({fault_mask_o, prio_mask_o, not_permitted_o}, {psc_x[i][1:0], psc_x[i][2]}, "mask");
		end
		$display("state change test done");
		for (int k = 0; k < 16; k++)
		begin
			issue(16'hF3AF, 16'h80F0 | k[15:0], 1'h1, 1'h1, 1'h0, '0, '0);
			chk({debug_hint_o, debug_option_o, flags_o}, {1'h1, k[3:0], expf}, "hint");
			@(posedge clk_i);
			lat <= k[3:0] & 4'h3;
			issue(16'hF3BF, 16'h8F50 | k[15:0], 1'h1, 1'h1, 1'h0, '0, '0);
			chk({mem_hold_o, stall_o, barrier_full_o}, 32'h5, "order");
			issue(16'h4288, 16'h0000, 1'h0, 1'h1, 1'h0, k, k);
			expf = 4'h6;
			chk(flags_o, expf, "pass order");
			wait_free(1'h0);
			issue(16'hF3BF, 16'h8F40 | k[15:0], 1'h1, 1'h1, 1'h0, '0, '0);
			chk({mem_hold_o, stall_o, barrier_full_o}, 32'h7, "complete");
			issue(16'h4288, 16'h0000, 1'h0, 1'h1, 1'h0, 32'h0, 32'h1);
			chk(flags_o, expf, "stalled");
			wait_free(1'h1);
		end
		$display("hint and barrier test done");
		reg_access(1'h0, ADDR_DEBUG, 32'hF);
		reg_access(1'h0, ADDR_FLAGS, {28'h0, expf});
		reg_access(1'h1, ADDR_MASKS, 32'h3);
		chk({fault_mask_o, prio_mask_o}, 32'h3, "mask write");
		reg_access(1'h0, ADDR_MASKS, 32'h3);
		reg_access(1'h0, ADDR_STATUS, 32'h4);
		reg_access(1'h1, ADDR_STATUS, 32'h4);
		reg_access(1'h0, ADDR_STATUS, 32'h0);
		reg_access(1'h0, 4'h2, 32'h0);
		$display("register test done");
		// Enable low freezes the core, so the offered compare is lost
		@(posedge clk_i);
		ce_i <= 1'h0;
		issue(16'h4288, 16'h0000, 1'h0, 1'h1, 1'h0, 32'h0, 32'h1);
		chk(flags_o, expf, "frozen");
		@(posedge clk_i);
		ce_i <= 1'h1;
		$display("enable test done");
		// Second reset in mid-run must clear the masks just written
		@(posedge clk_i);
		arst_n_i <= 1'h0;
		@(negedge clk_i);
		chk({flags_o, prio_mask_o, fault_mask_o, stall_o, mem_hold_o}, '0, "reset");
		@(posedge clk_i);
		arst_n_i <= 1'h1;
		issue(16'h4288, 16'h0000, 1'h0, 1'h1, 1'h0, 32'h9, 32'h9);
		chk(flags_o, 32'h6, "after reset");
		$display("reset test done");
		give_verdict();
	end
endmodule : compare_barrier_hint_exec_tb
